// ---- common/oecs_pkg.sv ----
// Contract
// - an 11-bit serial shift register plus a separate 11-bit control register
// - with program enable high, each of the first 11 shift clocks shifts serial data into stage 10
// - 11 pulses fill the shifter; the 12th pulse loads the control register
// - bit 0 enables the last output pair, bit 9 the first, reversed between
// - control bit 10 selects source: 0 routes input a, 1 routes input b
// - an enable bit low three-states its pair; high passes the selected clock
// - a shift clock with program enable low resets sequencer, shifter, control
// - only one control register load per reset; later pulses change nothing
// - program enable low, serial data high: all pairs on, input b routed
// - program enable low, serial data low: all pairs on, input a routed
// - a re-enabled output pair delivers its clock within 1.0 us
package oecs_pkg;

    // =========================================================
    // sizes and fields
    localparam int unsigned OECS_WORD_W   = 11;
    localparam int unsigned OECS_PAIRS    = 10;
    localparam int unsigned OECS_SEL_BIT  = 10;
    localparam int unsigned OECS_LOAD_CNT = 11;
    localparam logic [10:0] OECS_CTRL_RST = 11'h000;
    localparam logic [3:0]  OECS_CNT_RST  = 4'h0;

    // =========================================================
    // timing
    localparam int unsigned OECS_CLK_MHZ      = 200;
    localparam int unsigned OECS_STARTUP_NS   = 1000;
    localparam int unsigned OECS_STARTUP_CYC  = OECS_STARTUP_NS * OECS_CLK_MHZ / 1000;
    localparam int unsigned OECS_SHIFT_MAX_MHZ = 100;

    // =========================================================
    // carriers
    typedef struct packed {
        logic [9:0] pair_en;
        logic       src_b;
    } oecs_route_t;

    typedef enum logic [1:0] {
        OECS_IDLE,
        OECS_SHIFT,
        OECS_LOCKED
    } oecs_state_t;

endpackage : oecs_pkg

// ---- logic/oecs_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser; first stage is read only by the second
module oecs_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_ff <= '0;
            sync_o  <= '0;
        end
        else
        begin
            meta_ff <= async_i;
            sync_o  <= meta_ff;
        end
    end
endmodule : oecs_sync

// ---- logic/oecs_top.sv ----
`timescale 1ns/1ps
module oecs_top
    import oecs_pkg::*;
#(
    parameter int unsigned STARTUP_CYC = oecs_pkg::OECS_STARTUP_CYC
) (
    // system
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    // configuration pins
    input  wire logic       configuration_shift_clock_i,
    input  wire logic       serial_config_in_i,
    input  wire logic       program_enable_i,
    // clock sources
    input  wire logic       clock_input_a_i,
    input  wire logic       clock_input_b_i,
    // output pairs: index 0 is the first pair
    output logic [9:0]      output_pairs_o,
    output logic [9:0]      output_pairs_oe_o,
    // visibility
    output oecs_pkg::oecs_route_t route_o
);
    import oecs_pkg::*;

    // =========================================================
    // synchronise pins
    logic [4:0] pins_sync;

    oecs_sync #(.WIDTH(5)) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .async_i   ({configuration_shift_clock_i, serial_config_in_i, program_enable_i,
                     clock_input_a_i, clock_input_b_i}),
        .sync_o    (pins_sync)
    );

    wire sck_s = pins_sync[4];
    wire sdi_s = pins_sync[3];
    wire pen_s = pins_sync[2];
    wire cka_s = pins_sync[1];
    wire ckb_s = pins_sync[0];

    // =========================================================
    // shift clock edge detect
    logic       sck_d_ff;
    logic       sdi_d_ff;
    logic       pen_d_ff;
    logic [2:0] arm_ff;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sck_d_ff <= 1'b1;
            sdi_d_ff <= 1'b0;
            pen_d_ff <= 1'b0;
            arm_ff   <= 3'h0;
        end
        else
        begin
            sck_d_ff <= sck_s;
            sdi_d_ff <= sdi_s;
            pen_d_ff <= pen_s;
            arm_ff   <= {arm_ff[1:0], 1'b1};
        end
    end

    // synchroniser wakes up low while the pin may idle high on its pull-up;
    // edges are ignored until the detector holds the real pin level
    wire sck_armed = arm_ff[2];
    // data and enable delayed with the clock so the sample pairs with its edge
    wire sck_rise  = sck_s & ~sck_d_ff & sck_armed;

    // =========================================================
    // sequencer, shifter and control register
    oecs_state_t      state_ff;
    logic [10:0]      shift_ff;
    logic [10:0]      ctrl_ff;
    logic [3:0]       cnt_ff;

    wire prog_edge  = sck_rise & pen_d_ff;
    wire reset_edge = sck_rise & ~pen_d_ff;
    // shifter is full once the count reaches the load point
    wire shift_full = (cnt_ff == 4'(OECS_LOAD_CNT));

    oecs_state_t nxt_state;
    logic [10:0] nxt_shift;
    logic [10:0] nxt_ctrl;
    logic [3:0]  nxt_cnt;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_cnt   = cnt_ff;
        if (reset_edge)
        begin
            nxt_state = OECS_IDLE;
            nxt_shift = OECS_CTRL_RST;
            nxt_ctrl  = OECS_CTRL_RST;
            nxt_cnt   = OECS_CNT_RST;
        end
        else if (prog_edge)
        begin
            case (state_ff)
                OECS_IDLE, OECS_SHIFT:
                begin
                    if (!shift_full)
                    begin
                        // first bit ends up at index 0, last (select) at index 10
                        nxt_shift = {sdi_d_ff, shift_ff[10:1]};
                        nxt_cnt   = cnt_ff + 4'h1;
                        nxt_state = OECS_SHIFT;
                    end
                    else
                    begin
                        nxt_ctrl  = shift_ff;
                        nxt_state = OECS_LOCKED;
                    end
                end
                OECS_LOCKED:
                    // one load per reset: further edges change nothing
                    nxt_state = OECS_LOCKED;
                default:
                    nxt_state = OECS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_ff <= OECS_IDLE;
            shift_ff <= OECS_CTRL_RST;
            ctrl_ff  <= OECS_CTRL_RST;
            cnt_ff   <= OECS_CNT_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            ctrl_ff  <= nxt_ctrl;
            cnt_ff   <= nxt_cnt;
        end
    end

    // =========================================================
    // route decode
    oecs_route_t prog_route;
    oecs_route_t std_route;
    oecs_route_t nxt_route;

    // control register holds nothing useful until loaded: keep all on
    wire ctrl_live = (state_ff == OECS_LOCKED);

    always_comb
    begin
        for (int i = 0; i < 10; i++)
            prog_route.pair_en[i] = ctrl_ff[9 - i];
        prog_route.src_b      = ctrl_ff[OECS_SEL_BIT];
        std_route.pair_en     = 10'h3FF;
        std_route.src_b       = sdi_s;
        nxt_route = (pen_s && ctrl_live) ? prog_route : std_route;
    end

    // =========================================================
    // startup hold after re-enable
    logic [9:0]  en_prev_ff;
    logic [9:0]  live_ff;
    logic [15:0] start_cnt_ff [10];

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            route_o    <= '{pair_en: 10'h3FF, src_b: 1'b0};
            en_prev_ff <= 10'h3FF;
            live_ff    <= 10'h3FF;
            for (int i = 0; i < 10; i++)
                start_cnt_ff[i] <= 16'h0000;
        end
        else
        begin
            route_o    <= nxt_route;
            en_prev_ff <= nxt_route.pair_en;
            for (int i = 0; i < 10; i++)
            begin
                if (!nxt_route.pair_en[i])
                begin
                    live_ff[i]      <= 1'b0;
                    start_cnt_ff[i] <= 16'h0000;
                end
                else if (!en_prev_ff[i])
                    start_cnt_ff[i] <= 16'h0001;
                else if (!live_ff[i])
                begin
                    // bounded well under the startup limit
                    if (start_cnt_ff[i] >= 16'(STARTUP_CYC / 2))
                        live_ff[i] <= 1'b1;
                    else
                        start_cnt_ff[i] <= start_cnt_ff[i] + 16'h0001;
                end
            end
        end
    end

    // =========================================================
    // output drivers
    wire src_clk = route_o.src_b ? ckb_s : cka_s;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            output_pairs_o    <= 10'h000;
            output_pairs_oe_o <= 10'h000;
        end
        else
        begin
            output_pairs_oe_o <= route_o.pair_en & live_ff;
            output_pairs_o    <= {10{src_clk}} & route_o.pair_en & live_ff;
        end
    end

endmodule : oecs_top

// ---- tb/oecs_checker.sv ----
`timescale 1ns/1ps
// ==========
// port-level checks of the routing outputs
module oecs_checker
    import oecs_pkg::*;
(
    // system and pins
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic        configuration_shift_clock_i,
    input wire logic        serial_config_in_i,
    input wire logic        program_enable_i,
    input wire logic        clock_input_a_i,
    // outputs
    input wire logic [9:0]  output_pairs_o,
    input wire logic [9:0]  output_pairs_oe_o,
    input wire oecs_route_t route_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    reset_state_a: assert property ($rose(reset_n_i) |->
        output_pairs_oe_o == 10'h000 && route_o == 11'h7FE) else $error("bad reset state");
    oe_gated_a: assert property (
        (output_pairs_oe_o & ~$past(route_o.pair_en)) == 10'h000) else $error("pair not off");
    all_on_a: assert property ((!program_enable_i)[*8] |->
        route_o.pair_en == 10'h3FF) else $error("standard mode not all on");
    src_a_a: assert property ((!program_enable_i && !serial_config_in_i)[*8] |->
        !route_o.src_b) else $error("source a not chosen");
    src_b_a: assert property ((!program_enable_i && serial_config_in_i)[*8] |->
        route_o.src_b) else $error("source b not chosen");
    route_hold_a: assert property ((program_enable_i && !configuration_shift_clock_i
        && $stable(serial_config_in_i))[*8] |=> $stable(route_o)) else $error("route moved");
    reenable_a: assert property ($rose(route_o.pair_en[0]) |->
        ##[1:200] output_pairs_oe_o[0]) else $error("pair slow to start");
    pass_clock_a: assert property ($rose(clock_input_a_i) && output_pairs_oe_o[0]
        && !route_o.src_b |-> ##[1:6] (output_pairs_o[0] || !output_pairs_oe_o[0]
        || route_o.src_b)) else $error("clock a not passed");
endmodule : oecs_checker

bind oecs_top oecs_checker chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .configuration_shift_clock_i(configuration_shift_clock_i),
    .serial_config_in_i(serial_config_in_i), .program_enable_i(program_enable_i),
    .clock_input_a_i(clock_input_a_i), .output_pairs_o(output_pairs_o),
    .output_pairs_oe_o(output_pairs_oe_o), .route_o(route_o));

// ---- tb/oecs_ctrl_model.sv ----
`timescale 1ns/1ps
// ==========
// configuration controller; shift clock idles low between pulses
module oecs_ctrl_model (
    // pins
    input  wire logic clk_sys_i,
    output logic      configuration_shift_clock_o,
    output logic      serial_config_in_o,
    output logic      program_enable_o
);
    initial
    begin
        configuration_shift_clock_o = 1'b0;
        serial_config_in_o          = 1'b0;
        program_enable_o            = 1'b0;
    end
    task automatic set_pins(input logic en, input logic d);
        program_enable_o   = en;
        serial_config_in_o = d;
    endtask : set_pins
    // 25 cycles a pulse, 125 ns, well under the shifter limit
    task automatic pulse(input logic en, input logic d);
        set_pins(en, d);
        repeat (12) @(negedge clk_sys_i);
        configuration_shift_clock_o = 1'b1;
        repeat (13) @(negedge clk_sys_i);
        configuration_shift_clock_o = 1'b0;
    endtask : pulse
    task automatic load(input logic [10:0] w);
        pulse(1'b0, 1'b0);
        for (int i = 0; i < 11; i++)
            pulse(1'b1, w[i]);
        pulse(1'b1, 1'b0);
    endtask : load
endmodule : oecs_ctrl_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// ==========
// bench: controller model on the pins, routing checked at the ports
module tb_top;
    import oecs_pkg::*;
    logic        clk_sys_i       = 1'b0;
    logic        reset_n_i       = 1'b0;
    logic        clock_input_a_i = 1'b0;
    logic        clock_input_b_i = 1'b0;
    logic        sck;
    logic        sdi;
    logic        pen;
    logic [9:0]  pairs;
    logic [9:0]  pairs_oe;
    oecs_route_t route;
    logic [10:0] words [4] = '{11'h000, 11'h7FF, 11'h4A5, 11'h35A};
    int          fail_count = 0;
    int          cmp_count  = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    always #20 clock_input_a_i = ~clock_input_a_i;
    always #35 clock_input_b_i = ~clock_input_b_i;
    oecs_ctrl_model ctl (.clk_sys_i(clk_sys_i), .configuration_shift_clock_o(sck),
        .serial_config_in_o(sdi), .program_enable_o(pen));
    oecs_top #(.STARTUP_CYC(8)) uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .configuration_shift_clock_i(sck), .serial_config_in_i(sdi),
        .program_enable_i(pen), .clock_input_a_i(clock_input_a_i),
        .clock_input_b_i(clock_input_b_i), .output_pairs_o(pairs),
        .output_pairs_oe_o(pairs_oe), .route_o(route));
    task automatic conclude;
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    // first pair sits at bit 9 of the word
    function automatic logic [10:0] map_word(input logic [10:0] w);
        logic [10:0] r;
        r[0] = w[10];
        for (int k = 0; k < 10; k++)
            r[k + 1] = w[9 - k];
        return r;
    endfunction : map_word
    // rising edges per pair over 56 cycles: clock a (8 cycles) gives 7,
    // clock b (14 cycles) gives 4, a disabled pair none
    task automatic expect_clock(input logic [10:0] exp);
        int         rises [10];
        int         want;
        logic [9:0] prev;
        foreach (rises[k])
            rises[k] = 0;
        // let a source switch reach the output flops first
        repeat (4) @(negedge clk_sys_i);
        prev = pairs;
        repeat (56)
        begin
            @(negedge clk_sys_i);
            for (int k = 0; k < 10; k++)
                if (pairs[k] === 1'b1 && prev[k] === 1'b0)
                    rises[k]++;
            prev = pairs;
        end
        for (int k = 0; k < 10; k++)
        begin
            want = !exp[k + 1] ? 0 : (exp[0] ? 4 : 7);
            cmp_count++;
            if (rises[k] != want)
            begin
                fail_count++;
                $display("[ERR] %0t pair %0d rises %0d want %0d", $time, k, rises[k], want);
            end
        end
    endtask : expect_clock
    // bounded wait for routing and drivers to settle
    task automatic expect_route(input logic [10:0] exp);
        int n;
        n = 0;
        while (n < 300 && !(route === exp && pairs_oe === exp[10:1]))
        begin
            @(negedge clk_sys_i);
            n++;
        end
        cmp_count++;
        if (n == 300)
        begin
            fail_count++;
            $display("[ERR] %0t route %h oe %h want %h", $time, route, pairs_oe, exp);
            conclude();
        end
        expect_clock(exp);
    endtask : expect_route
    initial
    begin
        repeat (5) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        expect_route(11'h7FE);
        ctl.set_pins(1'b0, 1'b1);
        expect_route(11'h7FF);
        foreach (words[i])
        begin
            ctl.load(words[i]);
            expect_route(map_word(words[i]));
        end
        repeat (12) ctl.pulse(1'b1, 1'b1);
        expect_route(map_word(words[3]));
        ctl.set_pins(1'b0, 1'b1);
        expect_route(11'h7FF);
        ctl.pulse(1'b0, 1'b0);
        expect_route(11'h7FE);
        repeat (11) ctl.pulse(1'b1, 1'b0);
        expect_route(11'h7FE);
        ctl.pulse(1'b1, 1'b0);
        expect_route(11'h000);
        conclude();
    end
endmodule : tb_top
